// *** logic/pebc_pkg.sv ***
package pebc_pkg;

  typedef enum logic [2:0] {
    PEBC_NORM_SINGLE,
    PEBC_NORM_EXP_NARROW,
    PEBC_NORM_EXP_WIDE,
    PEBC_SPEC_SINGLE,
    PEBC_SPEC_EXP_NARROW,
    PEBC_SPEC_EXP_WIDE,
    PEBC_PERIPHERAL
  } pebc_mode_t;

  // Register offsets
  localparam logic [7:0] OFS_DIR   = 8'h09;
  localparam logic [7:0] OFS_FSEL  = 8'h0a;
  localparam logic [7:0] OFS_PULL  = 8'h0c;
  localparam logic [7:0] OFS_DRIVE = 8'h0d;

  // Implemented bits
  localparam logic [7:0] DIR_MASK   = 8'hfc;
  localparam logic [7:0] FSEL_MASK  = 8'hbc;
  localparam logic [7:0] PULL_MASK  = 8'h13;
  localparam logic [7:0] DRIVE_MASK = 8'h0b;

  // Function select fields
  localparam int FS_NO_DATA_ENABLE_BIT  = 7;
  localparam int FS_PIPE_OUTPUT_ENABLE = 5;
  localparam int FS_NO_E_CLOCK_BIT = 4;
  localparam int FS_LOW_STROBE_ENABLE = 3;
  localparam int FS_READ_WRITE_ENABLE  = 2;
  localparam logic [7:0] FS_ONCE_MASK = 8'h2c;

  // Pull-up and drive fields
  localparam int PU_PE = 4;
  localparam int PU_PB = 1;
  localparam int PU_PA = 0;
  localparam int RD_PE = 3;
  localparam int RD_PB = 1;
  localparam int RD_PA = 0;

  // Port E pins
  localparam int PIN_DBE   = 7;
  localparam int PIN_PIPE1 = 6;
  localparam int PIN_PIPE0 = 5;
  localparam int PIN_ECLK  = 4;
  localparam int PIN_STRB  = 3;
  localparam int PIN_RW    = 2;
  localparam logic [7:0] PE_PULL_SW     = 8'h8d;
  localparam logic [7:0] PE_PULL_ALWAYS = 8'h02;
  localparam logic [7:0] PE_OUT_CAPABLE = 8'hfc;

  // Mode dependent reset values of the function select register
  localparam logic [7:0] FSEL_RST_SINGLE = 8'h90;
  localparam logic [7:0] FSEL_RST_SPEC   = 8'h2c;
  localparam logic [7:0] FSEL_RST_EXP    = 8'h00;
  localparam logic [7:0] REG_ZERO        = 8'h00;

endpackage : pebc_pkg

// *** logic/pebc_port_ctrl.sv ***
module pebc_port_ctrl (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire pebc_pkg::pebc_mode_t op_mode,
  input  wire logic               emulate_port_e_bit,
  input  wire logic               internal_visibility_bit,
  input  wire logic               e_stretch_bit,
  input  wire logic               tagging_active,
  input  wire logic               e_clock_level,
  input  wire logic [7:0]         pe_pin_in,
  input  wire logic [7:0]         pa_dir,
  input  wire logic [7:0]         pb_dir,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [15:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_wr_wide,
  input  wire logic               reg_rd,
  output logic      [7:0]         reg_rdata,
  output logic                    reg_external,
  output logic                    mode_wr,
  output logic      [7:0]         mode_wdata,
  output logic      [7:0]         pe_out_en,
  output logic      [7:0]         pe_alt_en,
  output logic      [7:0]         pe_pullup,
  output logic      [7:0]         pa_pullup,
  output logic      [7:0]         pb_pullup,
  output logic                    port_e_reduced_drive,
  output logic                    port_b_reduced_drive,
  output logic                    port_a_reduced_drive,
  output logic      [7:0]         pe_pin_level,
  output logic                    low_byte_tag_input
);
  import pebc_pkg::*;

  function automatic logic is_single(input pebc_mode_t m);
    return (m == PEBC_NORM_SINGLE) || (m == PEBC_SPEC_SINGLE);
  endfunction : is_single

  function automatic logic is_special(input pebc_mode_t m);
    return (m == PEBC_SPEC_SINGLE) || (m == PEBC_SPEC_EXP_NARROW) ||
           (m == PEBC_SPEC_EXP_WIDE);
  endfunction : is_special

  function automatic logic is_expanded(input pebc_mode_t m);
    return (m == PEBC_NORM_EXP_NARROW) || (m == PEBC_NORM_EXP_WIDE) ||
           (m == PEBC_SPEC_EXP_NARROW) || (m == PEBC_SPEC_EXP_WIDE);
  endfunction : is_expanded

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs,
                               input logic present);
    return present && (a == ofs);
  endfunction : hit

  function automatic logic [7:0] fsel_reset(input pebc_mode_t m);
    logic [7:0] v;
    v = FSEL_RST_EXP;
    if (is_single(m) && !is_special(m)) begin
      v = FSEL_RST_SINGLE;
    end else if (m == PEBC_PERIPHERAL) begin
      v = FSEL_RST_SINGLE;
    end else if (is_special(m)) begin
      v = FSEL_RST_SPEC;
    end
    return v;
  endfunction : fsel_reset

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic [7:0] port_e_direction;
  logic [7:0] port_e_function_select;
  logic [7:0] pullup_control;
  logic [7:0] output_drive_reduction;
  logic       init_done;
  logic       fsel_seen;
  logic       drive_seen;
  logic [7:0] pe_sync1;
  logic       e_prev;

  logic       periph;
  logic       single;
  logic       special;
  logic       expanded;
  logic       dir_present;
  logic       map_present;
  logic [7:0] wbyte;
  logic       dir_wr;
  logic       fsel_wr;
  logic       pull_wr;
  logic       drive_wr;
  logic       once_ok;
  logic       no_e_clock_bit_ok;

  assign periph   = (op_mode == PEBC_PERIPHERAL);
  assign single   = is_single(op_mode);
  assign special  = is_special(op_mode);
  assign expanded = is_expanded(op_mode);
  // Emulation puts the direction register on the external bus instead
  assign dir_present = !periph && !(expanded && emulate_port_e_bit);
  assign map_present = !periph;
  assign wbyte    = reg_wr_wide ? reg_wdata[15:8] : reg_wdata[7:0];
  assign dir_wr   = reg_wr && init_done && hit(reg_addr, OFS_DIR, dir_present);
  assign fsel_wr  = reg_wr && init_done && hit(reg_addr, OFS_FSEL, map_present);
  assign pull_wr  = reg_wr && init_done && hit(reg_addr, OFS_PULL, map_present);
  assign drive_wr = reg_wr && init_done && hit(reg_addr, OFS_DRIVE, map_present);
  // Normal: first write only; special: every write but the first
  assign once_ok  = special ? fsel_seen : !fsel_seen;
  assign no_e_clock_bit_ok = (op_mode == PEBC_SPEC_SINGLE) ||
                    ((op_mode == PEBC_NORM_SINGLE) && !fsel_seen);

  // Mode pins are only trusted once reset has released
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_done <= 1'b0;
    end else begin
      init_done <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_e_direction <= REG_ZERO;
    end else if (dir_wr) begin
      port_e_direction <= wbyte & DIR_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_e_function_select <= REG_ZERO;
      fsel_seen              <= 1'b0;
    end else if (!init_done) begin
      port_e_function_select <= fsel_reset(op_mode);
    end else begin
      if (fsel_wr) begin
        fsel_seen <= 1'b1;
        port_e_function_select[FS_NO_DATA_ENABLE_BIT] <= wbyte[FS_NO_DATA_ENABLE_BIT];
        if (once_ok) begin
          port_e_function_select[FS_PIPE_OUTPUT_ENABLE] <= wbyte[FS_PIPE_OUTPUT_ENABLE];
          port_e_function_select[FS_LOW_STROBE_ENABLE] <= wbyte[FS_LOW_STROBE_ENABLE];
          port_e_function_select[FS_READ_WRITE_ENABLE]  <= wbyte[FS_READ_WRITE_ENABLE];
        end
        if (no_e_clock_bit_ok) begin
          port_e_function_select[FS_NO_E_CLOCK_BIT] <= wbyte[FS_NO_E_CLOCK_BIT];
        end
      end
      if (expanded) begin
        port_e_function_select[FS_NO_E_CLOCK_BIT] <= 1'b0;
      end
    end
  end

  // Low byte of a wide write goes to the neighbouring mode register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_wr    <= 1'b0;
      mode_wdata <= REG_ZERO;
    end else begin
      mode_wr <= fsel_wr && reg_wr_wide;
      if (fsel_wr && reg_wr_wide) begin
        mode_wdata <= reg_wdata[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pullup_control <= REG_ZERO;
    end else if (pull_wr) begin
      pullup_control <= wbyte & PULL_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      output_drive_reduction <= REG_ZERO;
      drive_seen             <= 1'b0;
    end else if (drive_wr) begin
      drive_seen <= 1'b1;
      if (special ? drive_seen : !drive_seen) begin
        output_drive_reduction <= wbyte & DRIVE_MASK;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata    <= REG_ZERO;
      reg_external <= 1'b0;
    end else begin
      reg_rdata <= REG_ZERO;
      if (reg_rd) begin
        if (hit(reg_addr, OFS_DIR, dir_present)) begin
          reg_rdata <= port_e_direction;
        end else if (hit(reg_addr, OFS_FSEL, map_present)) begin
          reg_rdata <= port_e_function_select & FSEL_MASK;
        end else if (hit(reg_addr, OFS_PULL, map_present)) begin
          reg_rdata <= pullup_control;
        end else if (hit(reg_addr, OFS_DRIVE, map_present)) begin
          reg_rdata <= output_drive_reduction;
        end
      end
      // Flags a hole in the on-chip map so the access is sent off chip
      reg_external <= (reg_rd || reg_wr) &&
                      (((reg_addr == OFS_DIR) && !dir_present) ||
                       (((reg_addr == OFS_FSEL) || (reg_addr == OFS_PULL) ||
                         (reg_addr == OFS_DRIVE)) && periph));
    end
  end

  // Pin function decode
  logic [7:0] next_alt;
  logic [7:0] next_oe;
  logic       eclk_on;
  logic       strb_on;

  assign eclk_on = single ? (!port_e_function_select[FS_NO_E_CLOCK_BIT] &&
                             (internal_visibility_bit || !e_stretch_bit))
                          : 1'b1;
  assign strb_on = port_e_function_select[FS_LOW_STROBE_ENABLE] && !single &&
                   (op_mode != PEBC_NORM_EXP_NARROW);

  always_comb begin
    next_alt            = REG_ZERO;
    next_alt[PIN_DBE]   = !port_e_function_select[FS_NO_DATA_ENABLE_BIT];
    next_alt[PIN_PIPE1] = port_e_function_select[FS_PIPE_OUTPUT_ENABLE] && !single;
    next_alt[PIN_PIPE0] = port_e_function_select[FS_PIPE_OUTPUT_ENABLE] && !single;
    next_alt[PIN_ECLK]  = eclk_on;
    next_alt[PIN_STRB]  = strb_on;
    next_alt[PIN_RW]    = port_e_function_select[FS_READ_WRITE_ENABLE] && !single;
  end

  // Every alternate function here is an output, so selection forces drive
  assign next_oe = (next_alt | port_e_direction) & PE_OUT_CAPABLE;

  // Held at zero until the mode reset value is loaded, so no pin drives early
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pe_alt_en <= REG_ZERO;
      pe_out_en <= REG_ZERO;
    end else if (init_done) begin
      pe_alt_en <= next_alt & PE_OUT_CAPABLE;
      pe_out_en <= next_oe;
    end
  end

  // Port A and B carry address/data in every mode but single-chip
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pull
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          pe_pullup[gi] <= 1'b0;
          pa_pullup[gi] <= 1'b0;
          pb_pullup[gi] <= 1'b0;
        end else begin
          pe_pullup[gi] <= PE_PULL_ALWAYS[gi] ||
                           (PE_PULL_SW[gi] && pullup_control[PU_PE] && !next_oe[gi]);
          pa_pullup[gi] <= pullup_control[PU_PA] && single && !pa_dir[gi];
          pb_pullup[gi] <= pullup_control[PU_PB] && single && !pb_dir[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_e_reduced_drive <= 1'b0;
      port_b_reduced_drive <= 1'b0;
      port_a_reduced_drive <= 1'b0;
    end else begin
      port_e_reduced_drive <= output_drive_reduction[RD_PE];
      port_b_reduced_drive <= output_drive_reduction[RD_PB];
      port_a_reduced_drive <= output_drive_reduction[RD_PA];
    end
  end

  // Pins are asynchronous to the bus clock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pe_sync1     <= REG_ZERO;
      pe_pin_level <= REG_ZERO;
    end else begin
      pe_sync1     <= pe_pin_in;
      pe_pin_level <= pe_sync1;
    end
  end

  // Tag sampling sees the pin two clocks late; fine while E is slow
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      e_prev             <= 1'b0;
      low_byte_tag_input <= 1'b0;
    end else begin
      e_prev             <= e_clock_level;
      low_byte_tag_input <= e_prev && !e_clock_level && !pe_pin_level[PIN_STRB] &&
                            tagging_active && expanded && special &&
                            port_e_function_select[FS_LOW_STROBE_ENABLE];
    end
  end

  sequence s_fsel_write;
    fsel_wr && !reg_wr_wide;
  endsequence
  sequence s_e_fall;
    e_prev && !e_clock_level;
  endsequence
  property p_irq_pins_input;
    pe_out_en[1:0] == 2'b00;
  endproperty
  a_irq_pins_input: assert property (p_irq_pins_input)
    else $error("interrupt pin driven");
  property p_gpio_dir;
    init_done |=> ((pe_out_en & ~pe_alt_en) == ($past(port_e_direction) & ~pe_alt_en));
  endproperty
  a_gpio_dir: assert property (p_gpio_dir)
    else $error("gpio drive does not follow direction");
  property p_alt_override;
    (pe_alt_en & ~pe_out_en) == 8'h00;
  endproperty
  a_alt_override: assert property (p_alt_override)
    else $error("alternate function pin not driven");
  property p_periph_locked;
    init_done && reg_wr && periph && (reg_addr == OFS_FSEL) |=>
      $stable(port_e_function_select);
  endproperty
  a_periph_locked: assert property (p_periph_locked)
    else $error("function select changed in peripheral mode");
  property p_no_e_clock_bit_exp;
    init_done && expanded && $stable(op_mode) |=> !port_e_function_select[FS_NO_E_CLOCK_BIT];
  endproperty
  a_no_e_clock_bit_exp: assert property (p_no_e_clock_bit_exp)
    else $error("no-E-clock set in expanded mode");
  property p_once_normal;
    s_fsel_write ##0 (!special && fsel_seen) |=>
      ((port_e_function_select & FS_ONCE_MASK) ==
       ($past(port_e_function_select) & FS_ONCE_MASK));
  endproperty
  a_once_normal: assert property (p_once_normal)
    else $error("once bit accepted a second write");
  property p_pipe_single;
    single ##1 single |-> pe_alt_en[PIN_PIPE1:PIN_PIPE0] == 2'b00;
  endproperty
  a_pipe_single: assert property (p_pipe_single)
    else $error("pipe outputs active in single-chip");
  property p_eclk_single;
    init_done && single && !port_e_function_select[FS_NO_E_CLOCK_BIT] && !e_stretch_bit |=>
      pe_alt_en[PIN_ECLK];
  endproperty
  a_eclk_single: assert property (p_eclk_single)
    else $error("E clock not on pin 4");
  property p_pull_inputs;
    ((pe_pullup & pe_out_en) & ~PE_PULL_ALWAYS) == 8'h00;
  endproperty
  a_pull_inputs: assert property (p_pull_inputs)
    else $error("pull-up on a driven pin");
  property p_dir_external;
    reg_rd && (reg_addr == OFS_DIR) && !dir_present |=> reg_external && (reg_rdata == 8'h00);
  endproperty
  a_dir_external: assert property (p_dir_external)
    else $error("absent direction register answered");
  property p_tag;
    s_e_fall ##0 (!pe_pin_level[PIN_STRB] && tagging_active && expanded && special &&
                  port_e_function_select[FS_LOW_STROBE_ENABLE]) |=> low_byte_tag_input;
  endproperty
  a_tag: assert property (p_tag)
    else $error("low byte tag missed");
  property p_wide_write;
    fsel_wr && reg_wr_wide |=> mode_wr && (mode_wdata == $past(reg_wdata[7:0]));
  endproperty
  a_wide_write: assert property (p_wide_write)
    else $error("wide write did not reach mode register");

endmodule : pebc_port_ctrl

// *** test/pebc_pad_model.sv ***
module pebc_pad_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] pe_pullup,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pe_pin_in
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] float_pat = 8'h5a;

  // Lines nobody drives must not look like a stable level to the synchroniser
  always @(posedge sys_clk) begin
    float_pat <= ~float_pat;
  end

  // Driven low on pin 3 at the falling E edge marks the low byte for tagging
  always_comb begin
    pe_pin_in = (ext_en & ext_val) | (~ext_en & pe_pullup) | (~ext_en & ~pe_pullup & float_pat);
  end
endmodule : pebc_pad_model

// *** test/test_pebc_port_ctrl.sv ***
module test_pebc_port_ctrl;
  import pebc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  pebc_mode_t  op_mode = PEBC_NORM_SINGLE;
  logic        emulate_port_e_bit = 1'b0;
  logic        internal_visibility_bit = 1'b0;
  logic        e_stretch_bit = 1'b0;
  logic        tagging_active = 1'b0;
  logic        e_clock_level = 1'b0;
  logic [7:0]  pe_pin_in;
  logic [7:0]  pa_dir = 8'h00;
  logic [7:0]  pb_dir = 8'h00;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_wr_wide = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata, mode_wdata, pe_out_en, pe_alt_en, pe_pullup, pa_pullup, pb_pullup;
  logic [7:0]  pe_pin_level;
  logic        reg_external, mode_wr, low_byte_tag_input;
  logic        port_e_reduced_drive, port_b_reduced_drive, port_a_reduced_drive;
  logic [7:0]  ext_en = 8'h08;
  logic [7:0]  ext_val = 8'h08;
  logic [7:0]  seed = 8'h28;
  logic [7:0]  rdat, mwd, cur, w, lo, alt;
  logic        rext, mw, absent;
  pebc_mode_t  md;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          tag_cnt = 0;

  always #20 sys_clk = ~sys_clk;

  pebc_port_ctrl pebc_port_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n), .op_mode(op_mode),
    .emulate_port_e_bit(emulate_port_e_bit), .internal_visibility_bit(internal_visibility_bit),
    .e_stretch_bit(e_stretch_bit), .tagging_active(tagging_active),
    .e_clock_level(e_clock_level), .pe_pin_in(pe_pin_in), .pa_dir(pa_dir), .pb_dir(pb_dir),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_wr_wide(reg_wr_wide),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_external(reg_external), .mode_wr(mode_wr),
    .mode_wdata(mode_wdata), .pe_out_en(pe_out_en), .pe_alt_en(pe_alt_en),
    .pe_pullup(pe_pullup), .pa_pullup(pa_pullup), .pb_pullup(pb_pullup),
    .port_e_reduced_drive(port_e_reduced_drive), .port_b_reduced_drive(port_b_reduced_drive),
    .port_a_reduced_drive(port_a_reduced_drive), .pe_pin_level(pe_pin_level),
    .low_byte_tag_input(low_byte_tag_input));

  pebc_pad_model pebc_pad_model_i (.sys_clk(sys_clk), .pe_pullup(pe_pullup), .ext_en(ext_en),
    .ext_val(ext_val), .pe_pin_in(pe_pin_in));

  always @(posedge sys_clk) begin
    if (low_byte_tag_input === 1'b1) tag_cnt++;
  end

  function automatic logic [7:0] rnd();
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    return seed;
  endfunction : rnd

  function automatic logic is_single(pebc_mode_t m);
    return m == PEBC_NORM_SINGLE || m == PEBC_SPEC_SINGLE;
  endfunction : is_single

  function automatic logic is_spec(pebc_mode_t m);
    return m == PEBC_SPEC_SINGLE || m == PEBC_SPEC_EXP_NARROW || m == PEBC_SPEC_EXP_WIDE;
  endfunction : is_spec

  function automatic logic [7:0] fsel_rst(pebc_mode_t m);
    if (m == PEBC_NORM_SINGLE || m == PEBC_PERIPHERAL) return FSEL_RST_SINGLE;
    return is_spec(m) ? FSEL_RST_SPEC : FSEL_RST_EXP;
  endfunction : fsel_rst

  function automatic logic [7:0] fsel_upd(pebc_mode_t m, logic [7:0] c, logic [7:0] v,
                                          logic first);
    logic [7:0] n;
    n = c;
    if (m == PEBC_PERIPHERAL) return c;
    n[FS_NO_DATA_ENABLE_BIT] = v[FS_NO_DATA_ENABLE_BIT];
    if (is_spec(m) != first) n = (n & ~FS_ONCE_MASK) | (v & FS_ONCE_MASK);
    if (!is_single(m)) n[FS_NO_E_CLOCK_BIT] = 1'b0;
    else if (is_spec(m) || first) n[FS_NO_E_CLOCK_BIT] = v[FS_NO_E_CLOCK_BIT];
    return n;
  endfunction : fsel_upd

  function automatic logic [7:0] exp_alt(pebc_mode_t m, logic [7:0] f);
    logic [7:0] a;
    logic       s;
    s = is_single(m);
    a = 8'h00;
    a[PIN_DBE] = !f[FS_NO_DATA_ENABLE_BIT];
    a[PIN_PIPE1] = f[FS_PIPE_OUTPUT_ENABLE] && !s;
    a[PIN_PIPE0] = f[FS_PIPE_OUTPUT_ENABLE] && !s;
    a[PIN_ECLK] = s ? (!f[FS_NO_E_CLOCK_BIT] && (internal_visibility_bit || !e_stretch_bit)) : 1'b1;
    a[PIN_STRB] = f[FS_LOW_STROBE_ENABLE] && !s && m != PEBC_NORM_EXP_NARROW;
    a[PIN_RW] = f[FS_READ_WRITE_ENABLE] && !s;
    return a;
  endfunction : exp_alt

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic wide);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_wr_wide <= wide;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wr_wide <= 1'b0;
    #1;
    mw = mode_wr;
    mwd = mode_wdata;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    rdat = reg_rdata;
    rext = reg_external;
  endtask : rd

  task automatic do_reset(input pebc_mode_t m);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    op_mode <= m;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask : do_reset

  task automatic tag_try(input logic v, input int exp);
    ext_val[PIN_STRB] <= v;
    repeat (4) @(posedge sys_clk);
    #1;
    chk(pe_pin_level & 8'h0a, v ? 8'h0a : 8'h02, "pin levels");
    tag_cnt = 0;
    @(posedge sys_clk);
    e_clock_level <= 1'b1;
    @(posedge sys_clk);
    e_clock_level <= 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
    chk(tag_cnt[7:0], exp[7:0], "tag pulses");
  endtask : tag_try

  task stop_test;
    $display("counts: %0d checked, %0d unexpected", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  initial begin
    #2_000_000;
    miscompares++;
    stop_test();
  end

  initial begin
    for (int m = 0; m < 7; m++) begin
      md = pebc_mode_t'(m);
      do_reset(md);
      w = rnd();
      {internal_visibility_bit, e_stretch_bit, emulate_port_e_bit} <= w[2:0];
      pa_dir <= rnd();
      pb_dir <= rnd();
      rd(OFS_FSEL);
      chk(rdat, md == PEBC_PERIPHERAL ? REG_ZERO : fsel_rst(md), "select reset");
      chk(rext, md == PEBC_PERIPHERAL, "select external");
      cur = fsel_rst(md);
      w = rnd();
      wr(OFS_FSEL, {8'h00, w}, 1'b0);
      cur = fsel_upd(md, cur, w, 1'b1);
      w = rnd();
      wr(OFS_FSEL, {8'h00, w}, 1'b0);
      cur = fsel_upd(md, cur, w, 1'b0);
      rd(OFS_FSEL);
      chk(rdat, md == PEBC_PERIPHERAL ? REG_ZERO : cur, "select write");
      wr(OFS_DRIVE, 16'h00ff, 1'b0);
      wr(OFS_DRIVE, 16'h000a, 1'b0);
      rd(OFS_DRIVE);
      w = md == PEBC_PERIPHERAL ? REG_ZERO : (is_spec(md) ? 8'h0a : 8'h0b);
      chk(rdat, w, "drive write");
      chk(rext, md == PEBC_PERIPHERAL, "drive external");
      chk({port_e_reduced_drive, port_b_reduced_drive, port_a_reduced_drive},
          {w[RD_PE], w[RD_PB], w[RD_PA]}, "drive pins");
      wr(OFS_PULL, 16'h0013, 1'b0);
      rd(OFS_PULL);
      chk(rdat, md == PEBC_PERIPHERAL ? REG_ZERO : PULL_MASK, "pull read");
      chk(rext, md == PEBC_PERIPHERAL, "pull external");
      chk(pa_pullup, is_single(md) ? ~pa_dir : REG_ZERO, "port a pull");
      chk(pb_pullup, is_single(md) ? ~pb_dir : REG_ZERO, "port b pull");
      absent = md == PEBC_PERIPHERAL || (!is_single(md) && emulate_port_e_bit);
      wr(OFS_DIR, 16'h00ff, 1'b0);
      rd(OFS_DIR);
      chk(rdat, absent ? REG_ZERO : DIR_MASK, "direction read");
      chk(rext, absent, "direction external");
      alt = exp_alt(md, cur);
      chk(pe_alt_en, alt, "pin functions");
      chk(pe_out_en & ~pe_alt_en, absent ? REG_ZERO : DIR_MASK & ~alt, "pin drive");
      chk(pe_out_en & 8'h03, REG_ZERO, "interrupt pins");
      if (md != PEBC_PERIPHERAL) begin
        w = rnd();
        lo = rnd();
        wr(OFS_FSEL, {w, lo}, 1'b1);
        chk({7'h00, mw}, 8'h01, "wide mode strobe");
        chk(mwd, lo, "wide mode byte");
        rd(OFS_FSEL);
        chk(rdat, fsel_upd(md, cur, w, 1'b0), "wide select");
      end
      $display("test mode %0d done", m);
    end
    do_reset(PEBC_NORM_SINGLE);
    repeat (4) begin
      w = rnd();
      wr(OFS_DIR, {8'h00, w}, 1'b0);
      rd(OFS_DIR);
      chk(rdat, w & DIR_MASK, "direction random");
      chk(pe_out_en, w & PE_OUT_CAPABLE, "direction pins");
    end
    wr(OFS_PULL, 16'h0010, 1'b0);
    wr(OFS_DIR, 16'h0084, 1'b0);
    repeat (3) @(posedge sys_clk);
    #1;
    chk(pe_pullup, (PE_PULL_SW | PE_PULL_ALWAYS) & ~8'h84, "port e pull on");
    wr(OFS_PULL, 16'h0000, 1'b0);
    repeat (3) @(posedge sys_clk);
    #1;
    chk(pe_pullup, PE_PULL_ALWAYS, "port e pull off");
    $display("test pull-ups done");
    do_reset(PEBC_SPEC_EXP_WIDE);
    tagging_active <= 1'b1;
    tag_try(1'b0, 1);
    tag_try(1'b1, 0);
    $display("test tagging done");
    stop_test();
  end
endmodule : test_pebc_port_ctrl
